// ==== hw/ftd_pkg.sv ====
// ****************************************************************
// shared constants of the threshold detector
// ****************************************************************
package ftd_pkg;
   // widths
   localparam int NCH = 4;
   localparam int SW = 14;
   localparam int MW = 13;
   localparam int DWW = 16;
   localparam int OW = 16;
   // converter pipeline depth in sample clocks, sample and overrange share it
   localparam int SAMPLE_LAT = 8;
   // worst case from exceeding sample to pin, in sample clocks
   localparam int UPPER_LAT_MAX = 30;
   // full scale magnitude is two to the thirteenth
   localparam logic [SW-1:0] MAG_FS = 14'h2000;
   localparam logic [MW-1:0] MAG_MAX = 13'h1FFF;
   // register offsets
   localparam logic [15:0] OFF_STATUS = 16'h0040;
   localparam logic [15:0] OFF_UP_LO = 16'h0247;
   localparam logic [15:0] OFF_UP_HI = 16'h0248;
   localparam logic [15:0] OFF_LO_LO = 16'h0249;
   localparam logic [15:0] OFF_LO_HI = 16'h024A;
   localparam logic [15:0] OFF_DW_LO = 16'h024B;
   localparam logic [15:0] OFF_DW_HI = 16'h024C;
   localparam logic [15:0] OFF_CTRL = 16'h0250;
   // field positions
   localparam int CTRL_DET_EN = 0;
   localparam int CTRL_OVR_CB = 1;
   localparam int STAT_OVR_LSB = 4;
   // reset values
   localparam logic [MW-1:0] UP_RST = 13'h1FFF;
   localparam logic [MW-1:0] LO_RST = 13'h0000;
   localparam logic [DWW-1:0] DW_RST = 16'h0001;
   localparam logic [DWW-1:0] DW_MIN = 16'h0001;
   localparam logic [7:0] CTRL_RST = 8'h01;
endpackage : ftd_pkg

// ==== hw/ftd_cfg_if.sv ====
`timescale 1ns/1ns
// ****************************************************************
// thresholds and dwell handed to every channel
// ****************************************************************
interface ftd_cfg_if;
   logic [12:0] upper;
   logic [12:0] lower;
   logic [15:0] dwell;
   logic det_en;
   modport src (output upper, output lower, output dwell, output det_en);
   modport dst (input upper, input lower, input dwell, input det_en);
endinterface : ftd_cfg_if

// ==== hw/ftd_chan.sv ====
`timescale 1ns/1ns
// ****************************************************************
// one channel: set on upper, clear after dwell below lower
// ****************************************************************
module ftd_chan
   import ftd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ftd_pkg::MW-1:0] mag_fast,
   input wire logic [ftd_pkg::MW-1:0] mag_slow,
   ftd_cfg_if.dst cfg,
   output logic ind
);
   logic ind_r;
   logic ind_nxt;
   logic [DWW-1:0] cnt_r;
   logic [DWW-1:0] cnt_nxt;
   logic [3:0] blank_r;
   logic [3:0] blank_nxt;
   wire over = cfg.det_en && (mag_fast > cfg.upper);
   // late samples older than the last exceed must not count towards a clear
   wire settled = (blank_r == 4'h0);
   wire below = settled && (mag_slow < cfg.lower);
   // zero dwell behaves as the least legal value
   wire [DWW-1:0] dwell_eff = (cfg.dwell < DW_MIN) ? DW_MIN : cfg.dwell;
   // cnt_r holds earlier below cycles, so this cycle makes it exceed the dwell
   wire expired = below && (cnt_r >= dwell_eff);

   // next state: a new exceed always wins over a pending clear
   always_comb begin
      ind_nxt = ind_r;
      cnt_nxt = '0;
      if (over) begin
         ind_nxt = 1'b1;
      end else if (!cfg.det_en) begin
         ind_nxt = 1'b0;
      end else if (ind_r && expired) begin
         ind_nxt = 1'b0;
      end else if (ind_r && below) begin
         cnt_nxt = cnt_r + 16'h0001;
      end else begin
         cnt_nxt = '0;
      end
   end

   // blanking: an exceed waits for its own sample to leave the pipeline
   always_comb begin
      blank_nxt = blank_r;
      if (over) begin
         blank_nxt = 4'(SAMPLE_LAT);
      end else if (blank_r != 4'h0) begin
         blank_nxt = blank_r - 4'h1;
      end
   end

   // state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ind_r <= 1'b0;
         cnt_r <= '0;
         blank_r <= 4'h0;
      end else begin
         ind_r <= ind_nxt;
         cnt_r <= cnt_nxt;
         blank_r <= blank_nxt;
      end
   end

   assign ind = ind_r;
endmodule : ftd_chan

// ==== hw/ftd_top.sv ====
`timescale 1ns/1ns
// ****************************************************************
// four channel fast threshold detector with overrange path
// ****************************************************************
module ftd_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [ftd_pkg::NCH-1:0][ftd_pkg::SW-1:0] sample_in,
   input wire logic [ftd_pkg::NCH-1:0] ovr_in,
   output logic [ftd_pkg::NCH-1:0][ftd_pkg::OW-1:0] data_out,
   output logic [ftd_pkg::NCH-1:0] ovr_out,
   output logic threshold_pin_ch_a,
   output logic threshold_pin_ch_b,
   output logic threshold_pin_ch_c,
   output logic threshold_pin_ch_d
);
   import ftd_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************

   // address match, used by both the write and the read decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == off);
   endfunction : hit

   // signed sample to 13-bit magnitude, full scale clamps to the top code
   function automatic logic [MW-1:0] mag_of(input logic [SW-1:0] s);
      logic [SW-1:0] a;
      a = s[SW-1] ? (~s + 14'h0001) : s;
      if (a >= MAG_FS) begin
         mag_of = MAG_MAX;
      end else begin
         mag_of = a[MW-1:0];
      end
   endfunction : mag_of

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [7:0] up_lo_r;
   logic [4:0] up_hi_r;
   logic [7:0] lo_lo_r;
   logic [4:0] lo_hi_r;
   logic [7:0] dw_lo_r;
   logic [7:0] dw_hi_r;
   logic [7:0] ctrl_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // write strobes
   wire wr_up_lo = reg_wr && hit(reg_addr, OFF_UP_LO);
   wire wr_up_hi = reg_wr && hit(reg_addr, OFF_UP_HI);
   wire wr_lo_lo = reg_wr && hit(reg_addr, OFF_LO_LO);
   wire wr_lo_hi = reg_wr && hit(reg_addr, OFF_LO_HI);
   wire wr_dw_lo = reg_wr && hit(reg_addr, OFF_DW_LO);
   wire wr_dw_hi = reg_wr && hit(reg_addr, OFF_DW_HI);
   wire wr_ctrl = reg_wr && hit(reg_addr, OFF_CTRL);

   // assembled fields, low byte first, high byte holds the top bits
   wire [MW-1:0] upper_val = {up_hi_r, up_lo_r};
   wire [MW-1:0] lower_val = {lo_hi_r, lo_lo_r};
   wire [DWW-1:0] dwell_val = {dw_hi_r, dw_lo_r};
   wire det_en = ctrl_r[CTRL_DET_EN];
   wire ovr_cb_en = ctrl_r[CTRL_OVR_CB];

   // byte registers; the pair is not double buffered, so software
   // should update a threshold while detection is off or accept a mixed
   // value from the first byte write until the second byte is written
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         up_lo_r <= UP_RST[7:0];
         up_hi_r <= UP_RST[MW-1:8];
      end else begin
         if (wr_up_lo) begin
            up_lo_r <= reg_wdata;
         end
         if (wr_up_hi) begin
            up_hi_r <= reg_wdata[4:0];
         end
      end
   end

   // lower threshold pair
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lo_lo_r <= LO_RST[7:0];
         lo_hi_r <= LO_RST[MW-1:8];
      end else begin
         if (wr_lo_lo) begin
            lo_lo_r <= reg_wdata;
         end
         if (wr_lo_hi) begin
            lo_hi_r <= reg_wdata[4:0];
         end
      end
   end

   // dwell pair
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dw_lo_r <= DW_RST[7:0];
         dw_hi_r <= DW_RST[DWW-1:8];
      end else begin
         if (wr_dw_lo) begin
            dw_lo_r <= reg_wdata;
         end
         if (wr_dw_hi) begin
            dw_hi_r <= reg_wdata;
         end
      end
   end

   // control
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= {6'h00, reg_wdata[1:0]};
      end
   end

   // ****************************************************************
   // converter pipeline
   // ****************************************************************

   // the sample, its overrange flag and its magnitude walk together so
   // the late lower compare and the overrange stay aligned with data
   logic [NCH-1:0][SW-1:0] smp_pipe [SAMPLE_LAT];
   logic [NCH-1:0] ovr_pipe [SAMPLE_LAT];
   logic [NCH-1:0][MW-1:0] mag_pipe [SAMPLE_LAT];
   logic [NCH-1:0][MW-1:0] mag_fast;

   // fast path magnitude straight from the converter output
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_mag
         assign mag_fast[c] = mag_of(sample_in[c]);
      end
   endgenerate

   // first stage takes the inputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smp_pipe[0] <= '0;
         ovr_pipe[0] <= '0;
         mag_pipe[0] <= '0;
      end else begin
         smp_pipe[0] <= sample_in;
         ovr_pipe[0] <= ovr_in;
         mag_pipe[0] <= mag_fast;
      end
   end

   // remaining stages
   genvar k;
   generate
      for (k = 1; k < SAMPLE_LAT; k++) begin : g_pipe
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               smp_pipe[k] <= '0;
               ovr_pipe[k] <= '0;
               mag_pipe[k] <= '0;
            end else begin
               smp_pipe[k] <= smp_pipe[k-1];
               ovr_pipe[k] <= ovr_pipe[k-1];
               mag_pipe[k] <= mag_pipe[k-1];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // detectors
   // ****************************************************************
   ftd_cfg_if cfg ();
   logic [NCH-1:0] ind;

   // one shared set of thresholds fans out to every channel
   assign cfg.upper = upper_val;
   assign cfg.lower = lower_val;
   assign cfg.dwell = dwell_val;
   assign cfg.det_en = det_en;

   // independent detector per channel
   generate
      for (c = 0; c < NCH; c++) begin : g_chan
         ftd_chan u_chan (
            .clk(clk),
            .rst(rst),
            .mag_fast(mag_fast[c]),
            .mag_slow(mag_pipe[SAMPLE_LAT-1][c]),
            .cfg(cfg),
            .ind(ind[c])
         );
      end
   endgenerate

   // ****************************************************************
   // outputs
   // ****************************************************************
   logic [NCH-1:0] pin_r;
   logic [NCH-1:0] ovr_out_r;
   logic [NCH-1:0][OW-1:0] data_r;
   logic [NCH-1:0][OW-1:0] data_nxt;

   // output words: sample left aligned, control bit under it when enabled,
   // otherwise the tail is zero
   generate
      for (c = 0; c < NCH; c++) begin : g_fmt
         assign data_nxt[c] = {smp_pipe[SAMPLE_LAT-1][c],
                               ovr_cb_en & ovr_pipe[SAMPLE_LAT-1][c],
                               1'b0};
      end
   endgenerate

   // pins re-timed once: two clocks from sample to pin, well inside the bound
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_r <= '0;
         ovr_out_r <= '0;
         data_r <= '0;
      end else begin
         pin_r <= ind;
         ovr_out_r <= ovr_pipe[SAMPLE_LAT-1];
         data_r <= data_nxt;
      end
   end

   assign threshold_pin_ch_a = pin_r[0];
   assign threshold_pin_ch_b = pin_r[1];
   assign threshold_pin_ch_c = pin_r[2];
   assign threshold_pin_ch_d = pin_r[3];
   assign ovr_out = ovr_out_r;
   assign data_out = data_r;

   // ****************************************************************
   // register read
   // ****************************************************************

   // status shows the live indicators and the aligned overrange flags;
   // it reads the detector state, so no separate clear exists
   wire [7:0] status_val = {ovr_out_r, ind};

   // read mux, unmapped addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (hit(reg_addr, OFF_STATUS)) begin
         rdata_nxt = status_val;
      end else if (hit(reg_addr, OFF_UP_LO)) begin
         rdata_nxt = up_lo_r;
      end else if (hit(reg_addr, OFF_UP_HI)) begin
         rdata_nxt = {3'h0, up_hi_r};
      end else if (hit(reg_addr, OFF_LO_LO)) begin
         rdata_nxt = lo_lo_r;
      end else if (hit(reg_addr, OFF_LO_HI)) begin
         rdata_nxt = {3'h0, lo_hi_r};
      end else if (hit(reg_addr, OFF_DW_LO)) begin
         rdata_nxt = dw_lo_r;
      end else if (hit(reg_addr, OFF_DW_HI)) begin
         rdata_nxt = dw_hi_r;
      end else if (hit(reg_addr, OFF_CTRL)) begin
         rdata_nxt = ctrl_r;
      end
   end

   // read data is captured on the strobe and held until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
endmodule : ftd_top

// ==== verif/ftd_checker.sv ====
`timescale 1ns/1ns
// ****************************************************************
// port level checks of the threshold detector
// ****************************************************************
module ftd_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [ftd_pkg::NCH-1:0][ftd_pkg::SW-1:0] sample_in,
   input wire logic [ftd_pkg::NCH-1:0] ovr_in,
   input wire logic [ftd_pkg::NCH-1:0][ftd_pkg::OW-1:0] data_out,
   input wire logic [ftd_pkg::NCH-1:0] ovr_out,
   input wire logic threshold_pin_ch_a,
   input wire logic threshold_pin_ch_b,
   input wire logic threshold_pin_ch_c,
   input wire logic threshold_pin_ch_d
);
   import ftd_pkg::*;
   logic [12:0] upper_r;
   logic [12:0] lower_r;
   logic [15:0] dwell_r;
   logic det_en_r;
   logic [7:0] bq_r;
   logic [16:0] run_r;
   wire [NCH-1:0] exc;
   wire [3:0] pins = {threshold_pin_ch_d, threshold_pin_ch_c, threshold_pin_ch_b, threshold_pin_ch_a};
   wire [16:0] dw_eff = (dwell_r == 16'h0000) ? 17'h00001 : {1'b0, dwell_r};
   // magnitude with the most negative code clamped to the top code
   function automatic logic [12:0] mag_of(input logic [13:0] s);
      logic [13:0] a;
      a = s[13] ? -s : s;
      mag_of = a[13] ? MAG_MAX : a[12:0];
   endfunction : mag_of
   // shadow of the threshold registers, kept from the write strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         upper_r <= UP_RST;
         lower_r <= LO_RST;
         dwell_r <= DW_RST;
         det_en_r <= 1'b1;
      end else if (reg_wr) begin
         case (reg_addr)
            OFF_UP_LO: upper_r[7:0] <= reg_wdata;
            OFF_UP_HI: upper_r[12:8] <= reg_wdata[4:0];
            OFF_LO_LO: lower_r[7:0] <= reg_wdata;
            OFF_LO_HI: lower_r[12:8] <= reg_wdata[4:0];
            OFF_DW_LO: dwell_r[7:0] <= reg_wdata;
            OFF_DW_HI: dwell_r[15:8] <= reg_wdata;
            OFF_CTRL: det_en_r <= reg_wdata[CTRL_DET_EN];
            default: ;
         endcase
      end
   end
   // channel a: below flags through the pipeline, then the unbroken run
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bq_r <= 8'h00;
         run_r <= 17'h00000;
      end else begin
         bq_r <= {bq_r[6:0], mag_of(sample_in[0]) < lower_r};
         run_r <= bq_r[7] ? run_r + 17'h00001 : 17'h00000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************************************************
   // assertions
   // ****************************************************************
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      assign exc[c] = det_en_r && (mag_of(sample_in[c]) > upper_r);
      pin_set_a: assert property (exc[c] |-> ##2 pins[c])
         else $error("indicator pin not set two clocks after exceed");
   end
   sequence fall_s;
      $fell(threshold_pin_ch_a) ##0 $past(det_en_r);
   endsequence
   sequence quiet_s;
      det_en_r && $past(det_en_r) && (&bq_r);
   endsequence
   rise_cause_a: assert property ($rose(threshold_pin_ch_a) |-> $past(exc[0], 2))
      else $error("indicator rose with no exceed");
   clear_dwell_a: assert property (fall_s |-> $past(run_r) >= dw_eff + 17'h00001)
      else $error("indicator cleared before the dwell ran out");
   clear_bound_a: assert property (quiet_s ##0 (run_r >= dw_eff + 17'h00002) |-> !pins[0])
      else $error("indicator held past the dwell");
   enable_off_a: assert property (!det_en_r [*3] |-> pins == 4'h0)
      else $error("indicator high while detection is off");
   ovr_delay_a: assert property (ovr_out == $past(ovr_in, 9))
      else $error("overrange not aligned with sample latency");
   data_delay_a: assert property (data_out[1][15:2] == $past(sample_in[1], 9))
      else $error("sample latency differs");
   unmapped_read_a: assert property (reg_rd && reg_addr[15:12] != 4'h0 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   upper_read_a: assert property (reg_rd && reg_addr == OFF_UP_HI |=> reg_rdata == {3'h0, upper_r[12:8]})
      else $error("upper threshold high byte reads wrong");
   dwell_read_a: assert property (reg_rd && reg_addr == OFF_DW_HI |=> reg_rdata == dwell_r[15:8])
      else $error("dwell high byte reads wrong");
endmodule : ftd_checker

// ==== verif/ftd_agc_model.sv ====
`timescale 1ns/1ns
// ****************************************************************
// gain control stand-in: counts indicator rises per pin
// ****************************************************************
module ftd_agc_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] pins,
   output logic [3:0][7:0] rises
);
   logic [3:0] prev_r;
   // each rise is one gain step; toggling would show as extra steps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_r <= 4'h0;
         rises <= '0;
      end else begin
         prev_r <= pins;
         for (int i = 0; i < 4; i++) begin
            if (pins[i] && !prev_r[i]) rises[i] <= rises[i] + 8'h01;
         end
      end
   end
endmodule : ftd_agc_model

// ==== verif/test_ftd_top.sv ====
`timescale 1ns/1ns
// ****************************************************************
// self checking bench of the threshold detector
// ****************************************************************
module test_ftd_top;
   import ftd_pkg::*;
   typedef struct {int ch; logic [13:0] smp; logic hit;} ftd_row_s;
   logic clk, rst, reg_wr, reg_rd;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [NCH-1:0][SW-1:0] sample_in;
   logic [NCH-1:0] ovr_in, ovr_out;
   logic [NCH-1:0][OW-1:0] data_out;
   logic [3:0] pins;
   logic [3:0][7:0] rises;
   int err_count = 0, n_checks = 0, cyc = 0, hi_n;
   // strict compare on both sides of the upper threshold, both signs, clamp
   ftd_row_s rows[6] = '{'{0, 14'h0101, 1'b1}, '{1, 14'h0100, 1'b0}, '{2, 14'h3EFF, 1'b1},
      '{3, 14'h3F00, 1'b0}, '{0, 14'h2000, 1'b1}, '{1, 14'h1FFF, 1'b1}};
   logic [15:0] ra[8] = '{OFF_UP_LO, OFF_UP_HI, OFF_LO_LO, OFF_LO_HI, OFF_DW_LO, OFF_DW_HI,
      OFF_CTRL, 16'h3000};
   logic [7:0] r0[8] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
   logic [7:0] wv[8] = '{8'h00, 8'hE1, 8'h80, 8'h00, 8'h04, 8'h00, 8'h01, 8'h55};
   logic [7:0] rb[8] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00};
   ftd_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_in(sample_in), .ovr_in(ovr_in),
      .data_out(data_out), .ovr_out(ovr_out), .threshold_pin_ch_a(pins[0]),
      .threshold_pin_ch_b(pins[1]), .threshold_pin_ch_c(pins[2]), .threshold_pin_ch_d(pins[3]));
   ftd_agc_model agc (.clk(clk), .rst(rst), .pins(pins), .rises(rises));
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // every task starts and ends just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      d = reg_rdata;
      tick(1);
   endtask : rd
   // one exceed on channel a, a mid level sample at step m, count pin high cycles
   task automatic dwell_run(input int m, input int exp_n);
      hi_n = 0;
      sample_in[0] = 14'h0200;
      tick(1);
      for (int i = 1; i < 400; i++) begin
         sample_in[0] = (i == m) ? 14'h00C0 : 14'h0000;
         tick(1);
         if (pins[0] !== 1'b1) break;
         hi_n++;
      end
      chk(16'(hi_n), 16'(exp_n));
   endtask : dwell_run
   // main sequence
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      sample_in = '0;
      ovr_in = 4'h0;
      tick(20);
      rst = 1'b0;
      tick(1);
      for (int k = 0; k < 8; k++) begin
         rd(ra[k], rv);
         chk(rv, r0[k]);
      end
      for (int k = 0; k < 8; k++) begin
         wr(ra[k], wv[k]);
         rd(ra[k], rv);
         chk(rv, rb[k]);
      end
      $display("test registers done");
      foreach (rows[k]) begin
         sample_in[rows[k].ch] = rows[k].smp;
         tick(1);
         sample_in = '0;
         tick(1);
         chk({12'h000, pins}, {12'h000, 4'(rows[k].hit) << rows[k].ch});
         tick(20);
      end
      $display("test row table done");
      dwell_run(0, 13);
      dwell_run(3, 16);
      wr(OFF_DW_HI, 8'h01);
      dwell_run(0, 269);
      wr(OFF_DW_HI, 8'h00);
      wr(OFF_DW_LO, 8'h01);
      dwell_run(0, 10);
      chk(rises[0], 8'h06);
      $display("test dwell done");
      wr(OFF_CTRL, 8'h03);
      ovr_in = 4'h8;
      sample_in[3] = 14'h0055;
      tick(1);
      ovr_in = 4'h0;
      sample_in = '0;
      tick(7);
      chk(ovr_out, 4'h0);
      tick(1);
      chk(ovr_out, 4'h8);
      chk(data_out[3], 16'h0156);
      ovr_in = 4'h4;
      sample_in[1] = 14'h0300;
      tick(12);
      rd(OFF_STATUS, rv);
      chk(rv, 8'h42);
      ovr_in = 4'h0;
      sample_in = '0;
      $display("test overrange done");
      wr(OFF_CTRL, 8'h00);
      sample_in[2] = 14'h0400;
      tick(3);
      chk({12'h000, pins}, 16'h0000);
      sample_in = '0;
      wr(OFF_CTRL, 8'h01);
      tick(20);
      $display("test enable done");
      close_out();
   end
endmodule : test_ftd_top
bind ftd_top ftd_checker chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_in(sample_in),
   .ovr_in(ovr_in), .data_out(data_out), .ovr_out(ovr_out),
   .threshold_pin_ch_a(threshold_pin_ch_a), .threshold_pin_ch_b(threshold_pin_ch_b),
   .threshold_pin_ch_c(threshold_pin_ch_c), .threshold_pin_ch_d(threshold_pin_ch_d));
